// ### rtl/dtc_pin_sync.sv
// Two-flop synchroniser and edge detector for the timer input pin.
// Assumes the pin is asynchronous to i_sys_clk.
`timescale 1ns/100ps
module dtc_pin_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // One edge at most per clock, from synchronised samples only
  assign o_rise = sync_reg & ~last_reg;
  assign o_fall = ~sync_reg & last_reg;

endmodule

// ### rtl/dtc_pkg.sv
// Shared constants and types for the timer channel.
// Assumes a 32-bit AHB-Lite register bus and a single 100 MHz system clock.
package dtc_pkg;

  localparam logic [7:0] DTC_MODE_OFS  = 8'h00;
  localparam logic [7:0] DTC_XMODE_OFS = 8'h04;
  localparam logic [7:0] DTC_EVENT_OFS = 8'h08;
  localparam logic [7:0] DTC_REF_OFS   = 8'h0C;
  localparam logic [7:0] DTC_CAPT_OFS  = 8'h10;
  localparam logic [7:0] DTC_COUNT_OFS = 8'h14;

  localparam int DTC_EV_CAPT_BIT = 0;
  localparam int DTC_EV_REF_BIT  = 1;

  typedef enum logic [1:0] {
    DTC_CLK_STOP,
    DTC_CLK_DIV1,
    DTC_CLK_DIV16,
    DTC_CLK_PIN
  } dtc_clk_sel_t;

  typedef enum logic [1:0] {
    DTC_EDGE_OFF,
    DTC_EDGE_RISE,
    DTC_EDGE_FALL,
    DTC_EDGE_ANY
  } dtc_edge_t;

  // Mode register, bit 0 upward: run, clock source, restart, irq enable,
  // output mode, capture edge, prescale
  typedef struct packed {
    logic [7:0]   prescale_value;
    dtc_edge_t    capture_edge;
    logic         output_mode_select;
    logic         reference_irq_enable;
    logic         restart_on_match;
    dtc_clk_sel_t clock_source;
    logic         enable_run;
  } dtc_mode_t;

  typedef struct packed {
    logic       dma_request_enable;
    logic [5:0] reserved;
    logic       half_word_increment;
  } dtc_xmode_t;

  localparam dtc_mode_t   DTC_MODE_RESET  = '0;
  localparam dtc_xmode_t  DTC_XMODE_RESET = '0;
  localparam logic [31:0] DTC_REF_RESET   = 32'hFFFF_FFFF;
  localparam logic [31:0] DTC_STEP_NORMAL = 32'h0000_0001;
  localparam logic [31:0] DTC_STEP_HALF   = 32'h0001_0001;
  localparam logic [3:0]  DTC_DIV16_LAST  = 4'hF;
  localparam logic        DTC_OUT_IDLE    = 1'b1;
  localparam logic [2:0]  DTC_HSIZE_WORD  = 3'h2;
  localparam int          DTC_HTRANS_BIT  = 1;

endpackage

// ### rtl/dtc_timer.sv
// Timer channel: counter, prescaler, reference compare, input capture,
// event flags and request outputs, with an AHB-Lite register slave.
// Assumes a single AHB-Lite master, one clock, synchronous reset.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
// What this block does
// - Match fires after reference plus one ticks
// - Qualifying input edge copies counter to capture
// - Counter reads freely; any whole-word write clears it
// - Source is clock/1, clock/16 or pin
// - Input pin synchronised, two to three cycles
// - Prescaler divides by field value plus one
// - Edge setting selects trigger; capture sets flag
// - Capture flag requests DMA or interrupt
// - Reference match sets reference flag
// - Reference flag plus enable requests DMA/interrupt
// - Restart setting zeroes counter on match
// - Match pulses output low or toggles it
// - Setting run bit clears and starts counter
// - Step is 1 or 65537 per tick
// - Writing one clears a flag, zero keeps
// - DMA acknowledge clears both event flags
// - Flags set regardless of request enables
// - Half-word mode mirrors low half upward
module dtc_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic        i_timer_input_pin,
  input  wire logic        i_dma_ack,
  output logic             o_timer_output_pin,
  output logic             o_irq_req,
  output logic             o_dma_req
);

  import dtc_pkg::*;

  dtc_mode_t   timer_mode_reg;
  dtc_xmode_t  extended_mode_reg;
  logic [31:0] reference_value_reg;
  logic [31:0] capture_value_reg;
  logic [31:0] timer_count_reg;
  logic [31:0] timer_count_next;
  logic        capture_event_flag_reg;
  logic        reference_event_flag_reg;
  logic [3:0]  div16_reg;
  logic [7:0]  prescale_reg;
  logic        wr_pending_reg;
  logic [7:0]  wr_addr_reg;

  logic        pin_rise;
  logic        pin_fall;
  logic        src_tick;
  logic        count_tick;
  logic        reference_match;
  logic        capture_hit;
  logic        addr_phase;
  logic        addr_in_map;
  logic        mode_wr;
  logic        xmode_wr;
  logic        event_wr;
  logic        reference_wr;
  logic        count_wr;
  logic        capture_req;
  logic        reference_req;
  logic [31:0] step;
  logic [31:0] sum;

  // Register file read view
  function automatic logic [31:0] read_word(input logic [7:0] ofs);
    logic [31:0] word;
    word = 32'h0000_0000;
    unique case (ofs)
      DTC_MODE_OFS:  word = {16'h0000, timer_mode_reg};
      DTC_XMODE_OFS: word = {24'h00_0000, extended_mode_reg};
      DTC_EVENT_OFS: begin
        word[DTC_EV_CAPT_BIT] = capture_event_flag_reg;
        word[DTC_EV_REF_BIT]  = reference_event_flag_reg;
      end
      DTC_REF_OFS:   word = reference_value_reg;
      DTC_CAPT_OFS:  word = capture_value_reg;
      DTC_COUNT_OFS: word = timer_count_reg;
      default:       word = 32'h0000_0000;
    endcase
    return word;
  endfunction

  // Write strobe for one register in the data phase
  function automatic logic wr_hit(input logic [7:0] ofs);
    return wr_pending_reg && (wr_addr_reg == ofs);
  endfunction

  // Software clear of one event flag in a write data phase
  function automatic logic flag_clear(input int pos);
    return event_wr && i_hwdata[pos];
  endfunction

  dtc_pin_sync u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_pin     (i_timer_input_pin),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_phase = i_hsel && i_hready && i_htrans[DTC_HTRANS_BIT];
  assign addr_in_map = (i_haddr[31:8] == 24'h00_0000);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_hreadyout <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
    end
  end

  // Every transfer ends with an OKAY response
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_hresp <= 1'b0;
    end else begin
      o_hresp <= 1'b0;
    end
  end

  // Only whole-word writes inside the map are performed
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_pending_reg <= 1'b0;
    end else if (i_hready) begin
      wr_pending_reg <= addr_phase && addr_in_map && i_hwrite &&
                        (i_hsize == DTC_HSIZE_WORD);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_addr_reg <= 8'h00;
    end else if (addr_phase) begin
      wr_addr_reg <= i_haddr[7:0];
    end
  end

  // A read right behind a write still sees the old value
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_phase && !i_hwrite) begin
      o_hrdata <= addr_in_map ? read_word(i_haddr[7:0]) : 32'h0000_0000;
    end
  end

  assign mode_wr      = wr_hit(DTC_MODE_OFS);
  assign xmode_wr     = wr_hit(DTC_XMODE_OFS);
  assign event_wr     = wr_hit(DTC_EVENT_OFS);
  assign reference_wr = wr_hit(DTC_REF_OFS);
  assign count_wr     = wr_hit(DTC_COUNT_OFS);

  // Configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      timer_mode_reg <= DTC_MODE_RESET;
    end else if (mode_wr) begin
      timer_mode_reg <= dtc_mode_t'(i_hwdata[15:0]);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      extended_mode_reg <= DTC_XMODE_RESET;
    end else if (xmode_wr) begin
      extended_mode_reg.dma_request_enable  <= i_hwdata[7];
      extended_mode_reg.half_word_increment <= i_hwdata[0];
      extended_mode_reg.reserved            <= 6'h00;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      reference_value_reg <= DTC_REF_RESET;
    end else if (reference_wr) begin
      reference_value_reg <= i_hwdata;
    end
  end

  // Clock source and prescaler
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !timer_mode_reg.enable_run) begin
      div16_reg <= 4'h0;
    end else if (timer_mode_reg.clock_source == DTC_CLK_DIV16) begin
      div16_reg <= div16_reg + 4'h1;
    end
  end

  always_comb begin
    unique case (timer_mode_reg.clock_source)
      DTC_CLK_STOP:  src_tick = 1'b0;
      DTC_CLK_DIV1:  src_tick = 1'b1;
      DTC_CLK_DIV16: src_tick = (div16_reg == DTC_DIV16_LAST);
      DTC_CLK_PIN:   src_tick = pin_rise;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !timer_mode_reg.enable_run) begin
      prescale_reg <= 8'h00;
    end else if (src_tick) begin
      if (prescale_reg == timer_mode_reg.prescale_value) begin
        prescale_reg <= 8'h00;
      end else begin
        prescale_reg <= prescale_reg + 8'h01;
      end
    end
  end

  assign count_tick = timer_mode_reg.enable_run && src_tick &&
                      (prescale_reg == timer_mode_reg.prescale_value);

  // A match is seen when the next increment is due at the reference value
  assign reference_match = count_tick && (timer_count_reg == reference_value_reg);

  // Counter
  assign step = extended_mode_reg.half_word_increment ? DTC_STEP_HALF
                                                      : DTC_STEP_NORMAL;
  assign sum  = timer_count_reg + step;

  always_comb begin
    timer_count_next = timer_count_reg;
    if (count_wr || !timer_mode_reg.enable_run) begin
      timer_count_next = 32'h0000_0000;
    end else if (reference_match && timer_mode_reg.restart_on_match) begin
      timer_count_next = 32'h0000_0000;
    end else if (count_tick) begin
      if (extended_mode_reg.half_word_increment) begin
        timer_count_next = {sum[15:0], sum[15:0]};
      end else begin
        timer_count_next = sum;
      end
    end
  end

  // Held at zero while stopped, so setting the run bit starts from zero
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      timer_count_reg <= 32'h0000_0000;
    end else begin
      timer_count_reg <= timer_count_next;
    end
  end

  // Input capture
  always_comb begin
    unique case (timer_mode_reg.capture_edge)
      DTC_EDGE_OFF:  capture_hit = 1'b0;
      DTC_EDGE_RISE: capture_hit = pin_rise;
      DTC_EDGE_FALL: capture_hit = pin_fall;
      DTC_EDGE_ANY:  capture_hit = pin_rise | pin_fall;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      capture_value_reg <= 32'h0000_0000;
    end else if (capture_hit) begin
      capture_value_reg <= timer_count_reg;
    end
  end

  // Event flags: a new event wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      capture_event_flag_reg <= 1'b0;
    end else if (capture_hit) begin
      capture_event_flag_reg <= 1'b1;
    end else if (i_dma_ack) begin
      capture_event_flag_reg <= 1'b0;
    end else if (flag_clear(DTC_EV_CAPT_BIT)) begin
      capture_event_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      reference_event_flag_reg <= 1'b0;
    end else if (reference_match) begin
      reference_event_flag_reg <= 1'b1;
    end else if (i_dma_ack) begin
      reference_event_flag_reg <= 1'b0;
    end else if (flag_clear(DTC_EV_REF_BIT)) begin
      reference_event_flag_reg <= 1'b0;
    end
  end

  // Requests
  assign capture_req   = capture_event_flag_reg &&
                         (timer_mode_reg.capture_edge != DTC_EDGE_OFF);
  assign reference_req = reference_event_flag_reg &&
                         timer_mode_reg.reference_irq_enable;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_dma_req <= 1'b0;
    end else begin
      o_dma_req <= extended_mode_reg.dma_request_enable &&
                   (capture_req || reference_req);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= !extended_mode_reg.dma_request_enable &&
                   (capture_req || reference_req);
    end
  end

  // Output pin: one-cycle low pulse, or toggle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_timer_output_pin <= DTC_OUT_IDLE;
    end else if (reference_match) begin
      if (timer_mode_reg.output_mode_select) begin
        o_timer_output_pin <= ~o_timer_output_pin;
      end else begin
        o_timer_output_pin <= 1'b0;
      end
    end else if (!timer_mode_reg.output_mode_select) begin
      o_timer_output_pin <= DTC_OUT_IDLE;
    end
  end

endmodule

// ### verif/dtc_dma_model.sv
// DMA controller stand-in: acknowledges a pending request after a delay.
// Assumes the request is a level held until the flags clear.
`timescale 1ns/100ps
module dtc_dma_model #(
  parameter int ACK_DELAY = 3
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_enable,
  input  wire logic i_dma_req,
  output logic      o_dma_ack
);
  int wait_cnt;
  always @(posedge i_sys_clk) begin
    if (i_reset || !i_enable || !i_dma_req || o_dma_ack) begin
      wait_cnt <= 0;
      o_dma_ack <= 1'b0;
    end else if (wait_cnt == ACK_DELAY) begin
      o_dma_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ### verif/dtc_monitor.sv
// Port checker for the timer channel: bus answers and request levels.
// Assumes one clock and synchronous reset; bound to dtc_timer below.
`timescale 1ns/100ps
module dtc_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        i_dma_ack,
  input wire logic        o_timer_output_pin,
  input wire logic        o_irq_req,
  input wire logic        o_dma_req
);
  logic req, wr, rd, hi_rd;
  assign req = i_hsel && i_hready && i_htrans[1];
  assign wr = req && i_hwrite;
  assign rd = req && !i_hwrite;
  assign hi_rd = rd && (i_haddr[31:8] != 24'h0);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_resp_okay: assert property (!o_hresp)
    else $error("response not okay");
  a_ready_high: assert property (!$past(i_reset) |-> o_hreadyout)
    else $error("wait state seen");
  a_ready_rise: assert property ($rose(o_hreadyout) |-> $past(i_reset, 2))
    else $error("ready rose late");
  a_rdata_hold: assert property (!$past(rd) |-> $stable(o_hrdata))
    else $error("read data moved");
  a_unmapped_zero: assert property ($past(hi_rd) |-> o_hrdata == 32'h0)
    else $error("high address read not zero");
  a_req_excl: assert property (!(o_irq_req && o_dma_req))
    else $error("both requests high");
  a_irq_fall: assert property (!$past(i_reset) && $fell(o_irq_req)
    |-> $past(wr, 3)) else $error("irq dropped alone");
  a_dma_fall: assert property (!$past(i_reset) && $fell(o_dma_req)
    |-> $past(wr, 3) || $past(i_dma_ack, 2)) else $error("dma dropped alone");
  c_irq: cover property ($rose(o_irq_req));
  c_dma_ack: cover property (o_dma_req && i_dma_ack);
  c_pulse: cover property ($fell(o_timer_output_pin) ##1 o_timer_output_pin);
endmodule

bind dtc_timer dtc_monitor u_dtc_monitor (
  .i_sys_clk, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout,
  .o_hresp, .o_hrdata, .i_dma_ack, .o_timer_output_pin, .o_irq_req, .o_dma_req);

// ### verif/tb_dtc_timer.sv
// Bench for the timer channel: registers, compare, capture, requests.
// Assumes the DMA stand-in model and the bound checker.
`timescale 1ns/100ps
module tb_dtc_timer;
  import dtc_pkg::*;
  typedef struct {logic w; logic [31:0] a, d, e;} dtc_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        pin = 1'b0;
  logic        ack_en = 1'b0;
  logic        pclk_on = 1'b0;
  logic        rdy, pout, irq, dma, ack;
  logic [31:0] rdata, q, cap;
  int          bad_count = 0;
  int          checks = 0;
  int          t;
  dtc_row_t    rows[12] = '{'{0, 32'h0, 32'h0, 32'h0}, '{0, 32'h4, 32'h0, 32'h0},
    '{0, 32'h8, 32'h0, 32'h0}, '{0, 32'hC, 32'h0, 32'hFFFF_FFFF}, '{0, 32'h10, 32'h0, 32'h0},
    '{0, 32'h14, 32'h0, 32'h0}, '{1, 32'hC, 32'h1234_5678, 32'h1234_5678},
    '{1, 32'h10, 32'h5A, 32'h0}, '{1, 32'h4, 32'hFFFF_FFFF, 32'h81},
    '{1, 32'h0, 32'hFF00, 32'hFF00}, '{1, 32'h18, 32'h77, 32'h0}, '{0, 32'h104, 32'h0, 32'h0}};
  logic [31:0] pm[5] = '{32'h1B, 32'h31B, 32'hFF1B, 32'h1D, 32'h1F};
  logic [31:0] pr[5] = '{32'h28, 32'h9, 32'h0, 32'h2, 32'h3};
  logic [31:0] pe[5] = '{32'h29, 32'h28, 32'h100, 32'h30, 32'h28};

  always #5 clk = ~clk;

  dtc_timer u_dtc_timer (
    .i_sys_clk(clk), .i_reset(rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(DTC_HSIZE_WORD), .i_hwdata(hwdata), .i_hready(rdy),
    .o_hreadyout(rdy), .o_hresp(), .o_hrdata(rdata), .i_timer_input_pin(pin),
    .i_dma_ack(ack), .o_timer_output_pin(pout), .o_irq_req(irq), .o_dma_req(dma));
  dtc_dma_model #(.ACK_DELAY(3)) u_dtc_dma_model (
    .i_sys_clk(clk), .i_reset(rst), .i_enable(ack_en), .i_dma_req(dma), .o_dma_ack(ack));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rdy_edge();
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 64);
    if (n >= 64) bad_count++;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy_edge();
    htrans <= 2'h0;
    hwdata <= d;
    rdy_edge();
    q = rdata;
  endtask
  // Cycles until the output pin next falls
  task automatic fall(output int n);
    logic p;
    n = 0;
    do begin p = pout; @(posedge clk); n++; end while (!(p === 1'b1 && pout === 1'b0) && n < 600);
  endtask
  task automatic conclude();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Slow external clock on the input pin, toggled every 5 bus clocks: one tenth of the bus clock
  initial forever begin
    repeat (5) @(posedge clk);
    if (pclk_on) pin <= ~pin;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e);
    end
    bus(1'b1, 32'h4, 32'h0);
    for (int i = 0; i < 5; i++) begin
      pclk_on <= (i == 4);
      // Stop first, so each setting starts counting from zero
      bus(1'b1, 32'h0, 32'h0);
      bus(1'b1, 32'hC, pr[i]);
      bus(1'b1, 32'h0, pm[i]);
      fall(t);
      fall(t);
      chk(t, pe[i]);
      @(posedge clk);
      chk({30'h0, irq, dma}, 32'h2);
    end
    pclk_on <= 1'b0;
    bus(1'b1, 32'h0, 32'h10);
    bus(1'b1, 32'h8, 32'h1);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(1'b1, 32'h8, 32'h2);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, 32'hC, 32'h14);
    bus(1'b1, 32'h4, 32'h80);
    bus(1'b1, 32'h0, 32'h33);
    fall(t);
    repeat (30) @(posedge clk);
    chk(32'(pout), 32'h0);
    chk({30'h0, irq, dma}, 32'h1);
    ack_en <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(dma), 32'h0);
    bus(1'b0, 32'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 32'h14, 32'hDEAD_BEEF);
    bus(1'b0, 32'h14, 32'h0);
    chk(q, 32'h0);
    ack_en <= 1'b0;
    bus(1'b1, 32'h4, 32'h0);
    for (int e = 1; e < 4; e++) begin
      pin <= (e == 2);
      bus(1'b1, 32'h0, 32'h3);
      bus(1'b1, 32'h8, 32'h3);
      bus(1'b1, 32'h0, 32'h3 | (e << 6));
      pin <= (e != 2);
      t = 0;
      do begin @(posedge clk); t++; end while (irq !== 1'b1 && t < 20);
      chk(32'(t inside {[3:6]}), 32'h1);
      bus(1'b0, 32'h10, 32'h0);
      cap = q;
      bus(1'b0, 32'h14, 32'h0);
      chk(32'(q > cap && cap != 32'h0), 32'h1);
      bus(1'b1, 32'h8, 32'h1);
      pin <= (e == 2);
      repeat (8) @(posedge clk);
      chk(32'(irq), 32'(e == 3));
    end
    bus(1'b1, 32'h8, 32'h3);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'hC, 32'h0003_0003);
    bus(1'b1, 32'h4, 32'h1);
    bus(1'b1, 32'h0, 32'h3);
    repeat (9) @(posedge clk);
    bus(1'b0, 32'h14, 32'h0);
    chk(q, {q[15:0], q[15:0]});
    chk(32'(q[15:0] > 16'h3), 32'h1);
    bus(1'b0, 32'h8, 32'h0);
    chk(q, 32'h2);
    chk(32'(irq), 32'h0);
    conclude();
  end
endmodule
